// ---- hw/pchg_ctrl.sv ----
// Controller end: per-bank spacing counters that gate command issue
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - PRECHARGE after READ: BL/2 and tRAS met
// - ACTIVATE waits tRP after PRECHARGE
// - READ-to-PRECHARGE covers analog time after CAS-2
// - tRTP starts BL/2 minus 8 after READ
// - PRECHARGE after write burst waits tWR
// - Write recovery starts on prefetch boundary
// - WRITE-to-PRECHARGE is WL+BL/2+1+RU(tWR/tCK)
// - Auto-precharge low keeps bank open
// - Auto-precharge high closes bank itself
// - READ auto-precharge delay nRTP, plus 8 at BL32
// - WRITE auto-precharge starts tWR after burst
// - ACTIVATE after auto-precharge needs tRP and tRC
// - Auto-precharge access allowed once tRCD met
// - Internal precharge postponed until tRAS met
// - WRITE then READ-AP: tWTR+nRTP covers tWR
// - All-bank flag closes all, else one bank
// - tRPab after all-bank, tRPpb after single
module pchg_ctrl (
    input wire logic clock_i,                              // System clock
    input wire logic srst_i,                               // Synchronous reset
    input wire logic req_valid_i,                          // Command request present
    input wire pchg_pkg::cmd_type req_cmd_i,               // Requested command
    input wire logic [pchg_pkg::BANK_W-1:0] req_bank_i,    // Target bank
    input wire logic req_ap_i,                             // Auto-precharge on READ or WRITE
    input wire logic req_all_i,                            // All-bank flag on PRECHARGE
    input wire logic bl32_i,                               // Burst length 32 when high
    output logic req_ready_o,                              // Request legal now
    output logic [pchg_pkg::NBANK-1:0] bank_open_o,        // Controller view of open rows
    pchg_link_if.ctrl link                                 // Commands to the memory end
);
    logic fire;
    logic bank_ok;
    logic is_rd;
    logic [pchg_pkg::NBANK-1:0] open_reg;
    logic [pchg_pkg::NBANK-1:0] ok_act;
    logic [pchg_pkg::NBANK-1:0] ok_rw;
    logic [pchg_pkg::NBANK-1:0] ok_pre;
    pchg_pkg::cnt_type wtr_reg;
    pchg_pkg::cnt_type rd_gap;
    pchg_pkg::cnt_type wr_gap;
    pchg_pkg::cnt_type rd_apd;

    // Gaps for the current burst length, all in whole clocks
    assign rd_gap = pchg_pkg::rd_pre_gap(bl32_i);
    assign wr_gap = pchg_pkg::wr_ap_delay(bl32_i);
    assign rd_apd = pchg_pkg::rd_ap_delay(bl32_i);
    assign is_rd = req_cmd_i == pchg_pkg::CMD_RD;

    // Legality of the offered request
    always_comb begin
        unique case (req_cmd_i)
            pchg_pkg::CMD_ACT: bank_ok = ok_act[req_bank_i];
            pchg_pkg::CMD_RD, pchg_pkg::CMD_WR, pchg_pkg::CMD_MWR: bank_ok = ok_rw[req_bank_i];
            pchg_pkg::CMD_PRE: bank_ok = req_all_i ? (&ok_pre) : ok_pre[req_bank_i];
            default: bank_ok = 1'b0; // Unknown command never taken
        endcase
    end

    assign req_ready_o = bank_ok;
    assign fire = req_valid_i && bank_ok;
    assign bank_open_o = open_reg;

    // Write-to-read turnaround, shared by all banks
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            wtr_reg <= pchg_pkg::CNT_ZERO;
        end else if (fire && (req_cmd_i == pchg_pkg::CMD_WR || req_cmd_i == pchg_pkg::CMD_MWR)) begin
            wtr_reg <= pchg_pkg::dec(pchg_pkg::cmax(wtr_reg,
                       pchg_pkg::cnt_type'(pchg_pkg::wr_end(bl32_i) + pchg_pkg::N_WTR)));
        end else begin
            wtr_reg <= pchg_pkg::dec(wtr_reg);
        end
    end

    // Each counter holds the clocks left before its command may go
    for (genvar i = 0; i < pchg_pkg::NBANK; i++) begin : g_bank
        logic hit;
        pchg_pkg::cnt_type ras_reg;
        pchg_pkg::cnt_type rc_reg;
        pchg_pkg::cnt_type rcd_reg;
        pchg_pkg::cnt_type pre_reg;
        pchg_pkg::cnt_type act_reg;
        pchg_pkg::cnt_type wrr_reg;
        pchg_pkg::cnt_type ap_at;
        pchg_pkg::cnt_type ap_act;

        assign hit = fire && ((req_bank_i == pchg_pkg::BANK_W'(i)) ||
                     (req_cmd_i == pchg_pkg::CMD_PRE && req_all_i));
        // Internal close lands no earlier than the end of tRAS
        assign ap_at = pchg_pkg::cmax(is_rd ? rd_apd : wr_gap, ras_reg);
        // Next ACTIVATE after auto-precharge: tRP from the close and tRC from ACTIVATE
        assign ap_act = pchg_pkg::cmax(rc_reg, pchg_pkg::cnt_type'(ap_at + pchg_pkg::N_RPPB));

        assign ok_act[i] = !open_reg[i] && act_reg == pchg_pkg::CNT_ZERO;
        // READ with auto-precharge may not close before write recovery ends
        assign ok_rw[i] = open_reg[i] && rcd_reg == pchg_pkg::CNT_ZERO &&
                          (!is_rd || (wtr_reg == pchg_pkg::CNT_ZERO &&
                          (!req_ap_i || wrr_reg <= rd_apd)));
        assign ok_pre[i] = pre_reg == pchg_pkg::CNT_ZERO;

        // Bank counters and open-row view
        always_ff @(posedge clock_i) begin
            if (srst_i) begin
                open_reg[i] <= 1'b0;
                ras_reg <= pchg_pkg::CNT_ZERO;
                rc_reg <= pchg_pkg::CNT_ZERO;
                rcd_reg <= pchg_pkg::CNT_ZERO;
                pre_reg <= pchg_pkg::CNT_ZERO;
                act_reg <= pchg_pkg::CNT_ZERO;
                wrr_reg <= pchg_pkg::CNT_ZERO;
            end else begin
                ras_reg <= pchg_pkg::dec(ras_reg);
                rc_reg <= pchg_pkg::dec(rc_reg);
                rcd_reg <= pchg_pkg::dec(rcd_reg);
                pre_reg <= pchg_pkg::dec(pre_reg);
                act_reg <= pchg_pkg::dec(act_reg);
                wrr_reg <= pchg_pkg::dec(wrr_reg);
                if (hit) begin
                    unique case (req_cmd_i)
                        pchg_pkg::CMD_ACT: begin
                            open_reg[i] <= 1'b1;
                            ras_reg <= pchg_pkg::dec(pchg_pkg::N_RAS);
                            rc_reg <= pchg_pkg::dec(pchg_pkg::N_RC);
                            rcd_reg <= pchg_pkg::dec(pchg_pkg::N_RCD);
                            pre_reg <= pchg_pkg::dec(pchg_pkg::N_RAS);
                        end
                        pchg_pkg::CMD_RD: begin
                            pre_reg <= pchg_pkg::dec(pchg_pkg::cmax(pre_reg, rd_gap));
                            if (req_ap_i) begin
                                open_reg[i] <= 1'b0;
                                act_reg <= pchg_pkg::dec(ap_act);
                            end
                        end
                        pchg_pkg::CMD_WR, pchg_pkg::CMD_MWR: begin
                            pre_reg <= pchg_pkg::dec(pchg_pkg::cmax(pre_reg, wr_gap));
                            wrr_reg <= pchg_pkg::dec(pchg_pkg::cmax(wrr_reg, wr_gap));
                            if (req_ap_i) begin
                                open_reg[i] <= 1'b0;
                                act_reg <= pchg_pkg::dec(ap_act);
                            end
                        end
                        pchg_pkg::CMD_PRE: begin
                            open_reg[i] <= 1'b0;
                            // Row cycle still counts from the last ACTIVATE
                            act_reg <= pchg_pkg::dec(pchg_pkg::cmax(rc_reg,
                                       req_all_i ? pchg_pkg::N_RPAB : pchg_pkg::N_RPPB));
                        end
                    endcase
                end
            end
        end
    end

    // Registered command toward the memory end
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            link.cmd_valid <= 1'b0;
            link.cmd <= pchg_pkg::CMD_ACT;
            link.bank <= '0;
            link.ap <= 1'b0;
            link.all_bank <= 1'b0;
            link.bl32 <= 1'b0;
        end else begin
            link.cmd_valid <= fire;
            link.cmd <= req_cmd_i;
            link.bank <= req_bank_i;
            link.ap <= req_ap_i;
            link.all_bank <= req_all_i;
            link.bl32 <= bl32_i;
        end
    end
endmodule : pchg_ctrl
`default_nettype wire

// ---- common/pchg_pkg.sv ----
// Shared timing constants, command codes and gap helpers for both ends
`default_nettype none
package pchg_pkg;
    // Clock and analog limits, in picoseconds
    localparam int T_CK_PS = 10000;
    localparam int T_RAS_PS = 42000;
    localparam int T_RCD_PS = 18000;
    localparam int T_RPPB_PS = 18000;
    localparam int T_RPAB_PS = 21000;
    localparam int T_RC_PS = 60000;
    localparam int T_WR_PS = 18000;
    localparam int T_WTR_PS = 10000;
    localparam int T_RTP_PS = 7500;
    // Least clock counts that bound the analog limits
    localparam int N_ONE = 1;
    localparam int N_RAS_MIN = 3;
    localparam int N_RCD_MIN = 4;
    localparam int N_RTP_MIN = 8;
    // Burst and latency figures, in clocks or data beats
    localparam int WL = 6;
    localparam int BL16_HALF = 8;
    localparam int BL32_HALF = 16;
    localparam int BL32_RTP_ADD = 8;
    localparam int RTP_OFS = 8;
    localparam int CAS2_EDGE = 3;
    localparam int WR_EDGE_ADD = 1;
    localparam int PREFETCH_BEATS = 16;
    localparam int BEATS_PER_CK = 2;
    // Array shape and counter width
    localparam int NBANK = 8;
    localparam int BANK_W = 3;
    localparam int CNT_W = 8;
    typedef logic [CNT_W-1:0] cnt_type;
    typedef enum logic [4:0] {
        CMD_ACT = 5'h01,
        CMD_RD = 5'h02,
        CMD_WR = 5'h04,
        CMD_MWR = 5'h08,
        CMD_PRE = 5'h10
    } cmd_type;
    // Time to clocks, rounded up, never below a least count
    function automatic int cyc_up(input int ps, input int least);
        int n;
        n = (ps + T_CK_PS - 1) / T_CK_PS;
        return (n > least) ? n : least;
    endfunction : cyc_up
    localparam cnt_type N_RAS = cnt_type'(cyc_up(T_RAS_PS, N_RAS_MIN));
    localparam cnt_type N_RCD = cnt_type'(cyc_up(T_RCD_PS, N_RCD_MIN));
    localparam cnt_type N_RPPB = cnt_type'(cyc_up(T_RPPB_PS, N_ONE));
    localparam cnt_type N_RPAB = cnt_type'(cyc_up(T_RPAB_PS, N_ONE));
    localparam cnt_type N_RC = cnt_type'(cyc_up(T_RC_PS, N_ONE));
    localparam cnt_type N_WR = cnt_type'(cyc_up(T_WR_PS, N_ONE));
    localparam cnt_type N_WTR = cnt_type'(cyc_up(T_WTR_PS, N_ONE));
    localparam cnt_type N_RTP = cnt_type'(cyc_up(T_RTP_PS, N_RTP_MIN));
    localparam cnt_type CNT_ZERO = cnt_type'(0);
    localparam cnt_type CNT_ONE = cnt_type'(1);
    // Larger of two counts
    function automatic cnt_type cmax(input cnt_type a, input cnt_type b);
        return (a > b) ? a : b;
    endfunction : cmax
    // Count down, holding at zero
    function automatic cnt_type dec(input cnt_type a);
        return (a == CNT_ZERO) ? CNT_ZERO : cnt_type'(a - CNT_ONE);
    endfunction : dec
    // Half the burst length, in clocks
    function automatic int bl_half(input logic bl32);
        return bl32 ? BL32_HALF : BL16_HALF;
    endfunction : bl_half
    // WRITE to the first edge after the last strobe, on a prefetch boundary
    function automatic cnt_type wr_end(input logic bl32);
        int groups;
        groups = (BEATS_PER_CK * bl_half(bl32) + PREFETCH_BEATS - 1) / PREFETCH_BEATS;
        return cnt_type'(WL + groups * PREFETCH_BEATS / BEATS_PER_CK + WR_EDGE_ADD);
    endfunction : wr_end
    // Least READ to PRECHARGE gap
    function automatic cnt_type rd_pre_gap(input logic bl32);
        int h;
        h = bl_half(bl32);
        return cmax(cnt_type'(h), cmax(cnt_type'(h - RTP_OFS + int'(N_RTP)), cnt_type'(CAS2_EDGE + int'(N_RTP))));
    endfunction : rd_pre_gap
    // READ to start of internal precharge
    function automatic cnt_type rd_ap_delay(input logic bl32);
        return bl32 ? cnt_type'(BL32_RTP_ADD + int'(N_RTP)) : N_RTP;
    endfunction : rd_ap_delay
    // WRITE to start of internal precharge, also the WRITE to PRECHARGE gap
    function automatic cnt_type wr_ap_delay(input logic bl32);
        return cnt_type'(wr_end(bl32) + N_WR);
    endfunction : wr_ap_delay
endpackage : pchg_pkg
`default_nettype wire

// ---- common/pchg_link_if.sv ----
// Command link between the controller end and the memory end
`timescale 1ns/10ps
`default_nettype none
interface pchg_link_if;
    logic cmd_valid;
    pchg_pkg::cmd_type cmd;
    logic [pchg_pkg::BANK_W-1:0] bank;
    logic ap;
    logic all_bank;
    logic bl32;
    // Controller drives every command field
    modport ctrl (output cmd_valid, output cmd, output bank, output ap, output all_bank, output bl32);
    // Memory end only samples
    modport dev (input cmd_valid, input cmd, input bank, input ap, input all_bank, input bl32);
endinterface : pchg_link_if
`default_nettype wire

// ---- hw/pchg_dev.sv ----
// Memory end: bank state, auto-precharge scheduling and RAS lockout
`timescale 1ns/10ps
`default_nettype none
module pchg_dev (
    input wire logic clock_i,                              // System clock
    input wire logic srst_i,                               // Synchronous reset
    pchg_link_if.dev link,                                 // Commands from the controller
    output logic [pchg_pkg::NBANK-1:0] bank_open_o,        // Bank holds an open row
    output logic [pchg_pkg::NBANK-1:0] prech_o,            // Bank is precharging
    output logic [pchg_pkg::NBANK-1:0] ap_start_o          // Auto-precharge began
);
    logic [pchg_pkg::NBANK-1:0] open_reg;
    logic [pchg_pkg::NBANK-1:0] prech_reg;
    logic [pchg_pkg::NBANK-1:0] aps_reg;

    // Status outputs straight from flops
    assign bank_open_o = open_reg;
    assign prech_o = prech_reg;
    assign ap_start_o = aps_reg;

    for (genvar i = 0; i < pchg_pkg::NBANK; i++) begin : g_bank
        logic hit;
        logic pend_reg;
        pchg_pkg::cnt_type ras_reg;
        pchg_pkg::cnt_type apc_reg;
        pchg_pkg::cnt_type rp_reg;
        logic ap_fire;

        // Command aimed at this bank, or a PRECHARGE to all banks
        assign hit = link.cmd_valid && ((link.bank == pchg_pkg::BANK_W'(i)) ||
                     (link.cmd == pchg_pkg::CMD_PRE && link.all_bank));
        // Pending close fires only once the row has been active long enough
        assign ap_fire = pend_reg && apc_reg == pchg_pkg::CNT_ZERO && ras_reg == pchg_pkg::CNT_ZERO;

        // Per-bank row state and precharge scheduling
        always_ff @(posedge clock_i) begin
            if (srst_i) begin
                open_reg[i] <= 1'b0;
                pend_reg <= 1'b0;
                ras_reg <= pchg_pkg::CNT_ZERO;
                apc_reg <= pchg_pkg::CNT_ZERO;
                rp_reg <= pchg_pkg::CNT_ZERO;
                aps_reg[i] <= 1'b0;
                prech_reg[i] <= 1'b0;
            end else begin
                ras_reg <= pchg_pkg::dec(ras_reg);
                apc_reg <= pchg_pkg::dec(apc_reg);
                rp_reg <= pchg_pkg::dec(rp_reg);
                aps_reg[i] <= 1'b0;
                if (rp_reg == pchg_pkg::CNT_ZERO) begin
                    prech_reg[i] <= 1'b0;
                end
                if (hit) begin
                    unique case (link.cmd)
                        pchg_pkg::CMD_ACT: begin
                            open_reg[i] <= 1'b1;
                            ras_reg <= pchg_pkg::dec(pchg_pkg::N_RAS);
                        end
                        pchg_pkg::CMD_RD: begin
                            // Without the flag the row simply stays open
                            if (link.ap) begin
                                pend_reg <= 1'b1;
                                apc_reg <= pchg_pkg::dec(pchg_pkg::rd_ap_delay(link.bl32));
                            end
                        end
                        pchg_pkg::CMD_WR, pchg_pkg::CMD_MWR: begin
                            if (link.ap) begin
                                pend_reg <= 1'b1;
                                // Recovery counted from the prefetch-aligned burst end
                                apc_reg <= pchg_pkg::dec(pchg_pkg::wr_ap_delay(link.bl32));
                            end
                        end
                        pchg_pkg::CMD_PRE: begin
                            open_reg[i] <= 1'b0;
                            pend_reg <= 1'b0;
                            prech_reg[i] <= 1'b1;
                            rp_reg <= pchg_pkg::dec(link.all_bank ? pchg_pkg::N_RPAB : pchg_pkg::N_RPPB);
                        end
                    endcase
                end else if (ap_fire) begin
                    open_reg[i] <= 1'b0;
                    pend_reg <= 1'b0;
                    aps_reg[i] <= 1'b1;
                    prech_reg[i] <= 1'b1;
                    rp_reg <= pchg_pkg::dec(pchg_pkg::N_RPPB);
                end
            end
        end
    end
endmodule : pchg_dev
`default_nettype wire

// ---- sim/pchg_checker.sv ----
// Spacing checks on the command link between the two ends
`timescale 1ns/10ps
`default_nettype none
module pchg_checker (
    input wire logic clock_i,                            // System clock
    input wire logic srst_i,                             // Synchronous reset
    input wire logic cmd_valid,                          // Command strobe
    input wire pchg_pkg::cmd_type cmd,                   // Command code
    input wire logic [pchg_pkg::BANK_W-1:0] bank,        // Target bank
    input wire logic ap,                                 // Auto-precharge flag
    input wire logic all_bank,                           // All-bank flag
    input wire logic bl32                                // Burst length 32
);
    localparam int RD_PRE16 = pchg_pkg::CAS2_EDGE + pchg_pkg::N_RTP;
    localparam int RD_PRE32 = pchg_pkg::BL32_HALF;
    localparam int WR_PRE16 = pchg_pkg::WL + pchg_pkg::BL16_HALF + 1 + pchg_pkg::N_WR;
    localparam int WR_PRE32 = pchg_pkg::WL + pchg_pkg::BL32_HALF + 1 + pchg_pkg::N_WR;
    localparam int RD_AP16 = pchg_pkg::N_RTP;
    localparam int RD_AP32 = pchg_pkg::BL32_RTP_ADD + pchg_pkg::N_RTP;
    // Cycles since each kind of command per bank: act, rd, wr, pre, pre all, rd ap, wr ap
    pchg_pkg::cnt_type age [7][8];
    wire logic is_act = cmd_valid && cmd == pchg_pkg::CMD_ACT;
    wire logic is_rd = cmd_valid && cmd == pchg_pkg::CMD_RD;
    wire logic is_wr = cmd_valid && (cmd == pchg_pkg::CMD_WR || cmd == pchg_pkg::CMD_MWR);
    wire logic is_pre = cmd_valid && cmd == pchg_pkg::CMD_PRE;
    wire logic pre_one = is_pre && !all_bank;
    // Command of kind k touches bank b
    function automatic logic hit(input int k, input int b);
        logic here;
        here = (bank == 3'(b));
        case (k)
            0: return is_act && here;
            1: return is_rd && here;
            2: return is_wr && here;
            3: return is_pre && (all_bank || here);
            4: return is_pre && all_bank;
            5: return is_rd && ap && here;
            default: return is_wr && ap && here;
        endcase
    endfunction : hit
    // Saturating age counters, long ago after reset
    always_ff @(posedge clock_i) begin
        for (int k = 0; k < 7; k++) begin
            for (int b = 0; b < 8; b++) begin
                if (srst_i) begin
                    age[k][b] <= 8'hff;
                end else if (hit(k, b)) begin
                    age[k][b] <= 8'h00;
                end else if (age[k][b] != 8'hff) begin
                    age[k][b] <= age[k][b] + 8'h01;
                end
            end
        end
    end
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (srst_i);
    // A command G cycles after another sees an age of G-1
    rd_pre_gap_a: assert property (pre_one |-> age[1][bank] >= (bl32 ? RD_PRE32 : RD_PRE16) - 1)
        else $error("precharge too soon after read");
    ras_pre_a: assert property (pre_one |-> age[0][bank] >= pchg_pkg::N_RAS - 1)
        else $error("precharge before active time met");
    wr_pre_a: assert property (pre_one |-> age[2][bank] >= (bl32 ? WR_PRE32 : WR_PRE16) - 1)
        else $error("precharge too soon after write");
    act_rp_a: assert property (is_act |-> age[3][bank] >= pchg_pkg::N_RPPB - 1 && age[4][bank] >= pchg_pkg::N_RPAB - 1)
        else $error("activate before precharge time");
    act_rc_a: assert property (is_act |-> age[0][bank] >= pchg_pkg::N_RC - 1)
        else $error("activate before cycle time");
    ap_rcd_a: assert property ((is_rd || is_wr) |-> age[0][bank] >= pchg_pkg::N_RCD - 1)
        else $error("access before row delay");
    wtr_rdap_a: assert property (is_rd && ap |-> age[2][bank] >= (bl32 ? WR_PRE32 - RD_AP32 : WR_PRE16 - RD_AP16) - 1)
        else $error("read with close cuts write recovery");
    act_rdap_a: assert property (is_act |-> age[5][bank] >= (bl32 ? RD_AP32 : RD_AP16) + pchg_pkg::N_RPPB - 1)
        else $error("activate before read close done");
    act_wrap_a: assert property (is_act |-> age[6][bank] >= (bl32 ? WR_PRE32 : WR_PRE16) + pchg_pkg::N_RPPB - 1)
        else $error("activate before write close done");
    // Main traffic kinds
    rd_ap_c: cover property (is_rd && ap);
    wr_ap_c: cover property (is_wr && ap);
    pre_all_c: cover property (is_pre && all_bank);
endmodule : pchg_checker
`default_nettype wire

// ---- sim/dram_precharge_timing_test.sv ----
// Self-checking bench joining controller end and memory end
`timescale 1ns/10ps
`default_nettype none
module dram_precharge_timing_test;
    localparam int LIMIT = 2000;
    logic clock_i;
    logic srst_i;
    logic req_valid_i;
    pchg_pkg::cmd_type req_cmd_i;
    logic [2:0] req_bank_i;
    logic req_ap_i;
    logic req_all_i;
    logic bl32_i;
    logic req_ready_o;
    logic [7:0] ctrl_open;
    logic [7:0] dev_open;
    logic [7:0] prech;
    logic [7:0] ap_start;
    int cyc;
    int mismatches;
    int n_compared;
    int ap_seen [8];
    int t0;
    int t1;
    int t2;
    pchg_link_if link ();
    pchg_ctrl i_pchg_ctrl (.clock_i(clock_i), .srst_i(srst_i), .req_valid_i(req_valid_i), .req_cmd_i(req_cmd_i),
        .req_bank_i(req_bank_i), .req_ap_i(req_ap_i), .req_all_i(req_all_i), .bl32_i(bl32_i),
        .req_ready_o(req_ready_o), .bank_open_o(ctrl_open), .link(link));
    pchg_dev i_pchg_dev (.clock_i(clock_i), .srst_i(srst_i), .link(link), .bank_open_o(dev_open),
        .prech_o(prech), .ap_start_o(ap_start));
    pchg_checker i_pchg_checker (.clock_i(clock_i), .srst_i(srst_i), .cmd_valid(link.cmd_valid), .cmd(link.cmd),
        .bank(link.bank), .ap(link.ap), .all_bank(link.all_bank), .bl32(link.bl32));
    // Clock
    initial begin
        clock_i = 1'h0;
        forever #5 clock_i = ~clock_i;
    end
    // Cycle count, close-start record and hang limit
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        for (int b = 0; b < 8; b++) begin
            if (ap_start[b] === 1'h1) ap_seen[b] <= cyc;
        end
        if (cyc == LIMIT) begin
            mismatches++;
            print_verdict();
        end
    end
    function automatic int mx(input int a, input int b);
        return (a > b) ? a : b;
    endfunction : mx
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    // Offer one request, return the cycle it was taken in
    task issue(input pchg_pkg::cmd_type c, input logic [2:0] b, input logic a, input logic al, output int t);
        int n;
        @(posedge clock_i);
        req_valid_i <= 1'h1;
        req_cmd_i <= c;
        req_bank_i <= b;
        req_ap_i <= a;
        req_all_i <= al;
        n = 0;
        #1;
        while (req_ready_o !== 1'h1 && n < 200) begin
            @(posedge clock_i);
            #1;
            n++;
        end
        check(n < 200, 1'h1);
        t = cyc;
        @(posedge clock_i);
        req_valid_i <= 1'h0;
        #1;
    endtask : issue
    task print_verdict();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : print_verdict
    // Main sequence
    initial begin
        srst_i = 1'h1;
        req_valid_i = 1'h0;
        req_cmd_i = pchg_pkg::CMD_ACT;
        req_bank_i = 3'h0;
        req_ap_i = 1'h0;
        req_all_i = 1'h0;
        bl32_i = 1'h0;
        cyc = 0;
        mismatches = 0;
        n_compared = 0;
        foreach (ap_seen[b]) ap_seen[b] = -1;
        repeat (6) @(posedge clock_i);
        srst_i <= 1'h0;
        issue(pchg_pkg::CMD_ACT, 3'h0, 1'h0, 1'h0, t0);
        issue(pchg_pkg::CMD_RD, 3'h0, 1'h0, 1'h0, t1);
        check(t1 - t0, pchg_pkg::N_RCD);
        check(dev_open[0], 1'h1);
        check(ap_seen[0], -1);
        issue(pchg_pkg::CMD_PRE, 3'h0, 1'h0, 1'h0, t2);
        check(t2 - t1, mx(pchg_pkg::BL16_HALF, mx(pchg_pkg::CAS2_EDGE + pchg_pkg::N_RTP,
            pchg_pkg::BL16_HALF - pchg_pkg::RTP_OFS + pchg_pkg::N_RTP)));
        issue(pchg_pkg::CMD_ACT, 3'h0, 1'h0, 1'h0, t0);
        check(t0 - t2, pchg_pkg::N_RPPB);
        $display("test 1 done");
        issue(pchg_pkg::CMD_WR, 3'h0, 1'h0, 1'h0, t1);
        issue(pchg_pkg::CMD_PRE, 3'h0, 1'h0, 1'h0, t2);
        check(t2 - t1, pchg_pkg::WL + pchg_pkg::BL16_HALF + 1 + pchg_pkg::N_WR);
        issue(pchg_pkg::CMD_ACT, 3'h0, 1'h0, 1'h0, t0);
        $display("test 2 done");
        issue(pchg_pkg::CMD_RD, 3'h0, 1'h1, 1'h0, t1);
        check(t1 - t0, pchg_pkg::N_RCD);
        issue(pchg_pkg::CMD_ACT, 3'h0, 1'h0, 1'h0, t2);
        check(ap_seen[0] - t1, pchg_pkg::N_RTP + 2);
        check(t2 - t1, pchg_pkg::N_RTP + pchg_pkg::N_RPPB);
        $display("test 3 done");
        @(posedge clock_i);
        bl32_i <= 1'h1;
        issue(pchg_pkg::CMD_ACT, 3'h1, 1'h0, 1'h0, t0);
        issue(pchg_pkg::CMD_RD, 3'h1, 1'h1, 1'h0, t1);
        issue(pchg_pkg::CMD_ACT, 3'h1, 1'h0, 1'h0, t2);
        check(ap_seen[1] - t1, pchg_pkg::BL32_RTP_ADD + pchg_pkg::N_RTP + 2);
        check(t2 - t1, pchg_pkg::BL32_RTP_ADD + pchg_pkg::N_RTP + pchg_pkg::N_RPPB);
        @(posedge clock_i);
        bl32_i <= 1'h0;
        $display("test 4 done");
        for (int k = 0; k < 2; k++) begin
            issue(pchg_pkg::CMD_ACT, 3'(2 + k), 1'h0, 1'h0, t0);
            issue(k ? pchg_pkg::CMD_MWR : pchg_pkg::CMD_WR, 3'(2 + k), 1'h1, 1'h0, t1);
            issue(pchg_pkg::CMD_ACT, 3'(2 + k), 1'h0, 1'h0, t2);
            check(ap_seen[2 + k] - t1, pchg_pkg::WL + pchg_pkg::BL16_HALF + 1 + pchg_pkg::N_WR + 2);
            check(t2 - t1, pchg_pkg::WL + pchg_pkg::BL16_HALF + 1 + pchg_pkg::N_WR + pchg_pkg::N_RPPB);
        end
        $display("test 5 done");
        issue(pchg_pkg::CMD_ACT, 3'h4, 1'h0, 1'h0, t0);
        issue(pchg_pkg::CMD_WR, 3'h4, 1'h0, 1'h0, t1);
        issue(pchg_pkg::CMD_RD, 3'h4, 1'h1, 1'h0, t2);
        check(t2 - t1, pchg_pkg::WL + pchg_pkg::BL16_HALF + 1 + pchg_pkg::N_WTR);
        $display("test 6 done");
        issue(pchg_pkg::CMD_ACT, 3'h5, 1'h0, 1'h0, t0);
        issue(pchg_pkg::CMD_ACT, 3'h6, 1'h0, 1'h0, t0);
        issue(pchg_pkg::CMD_PRE, 3'h5, 1'h0, 1'h0, t1);
        repeat (2) @(posedge clock_i);
        check(dev_open[6:5], 2'h2);
        issue(pchg_pkg::CMD_PRE, 3'h0, 1'h0, 1'h1, t1);
        @(posedge clock_i);
        #1;
        check(prech, 8'hff);
        issue(pchg_pkg::CMD_ACT, 3'h6, 1'h0, 1'h0, t2);
        check(t2 - t1, pchg_pkg::N_RPAB);
        repeat (2) @(posedge clock_i);
        check(dev_open, 8'h40);
        check(ctrl_open, 8'h40);
        $display("test 7 done");
        print_verdict();
    end
endmodule : dram_precharge_timing_test
`default_nettype wire
